// [design/mrc_parser.sv]
// Remote command interpreter for the power analyser listener/talker link
// Functional notes
// - Outside 488.2 mode, display source returns 40 display characters plus LF once per cycle.
// - Channel field is a two-digit sum of channel weights 1,2,4,8,16.
// - One digit after channels selects storing fundamentals (1) or not.
// - 24 function digits, each 1 includes a quantity; 11,18,19 unused.
// - Results store loads nothing until trigger, then at next cycle end.
// - Each further trigger re-arms the store for the next cycle end.
// - Integrator stop captures integrator results; start begins integration.
// - Channel codes 1-5; invalid for wiring ignored; valid resets display avg.
// - Top displays take 0-7; sum view takes 0 or 1.
// - Phase voltage choice applies only in three-phase four-wire wiring.
// - Main function is two digits 00-23; leading zero required.
// - Fast mode 1 disables harmonics, 0 restores them; default off.
// - Single harmonic order 00-99; resets display averaging.
// - Amps scale up/down, volts up only; factor at least one, one to five digits.
// - After a scaling command, rest of that line is ignored.
// - Harmonic limit 00-99 plus odd-only flag.
// - Service request enabled by 1 asserts request when data ready.
// - Status byte bits 0,1,2,5,6 as defined; 3,4,7 read zero.
// - Coupling select waits one second and resets both averagings.
// - Mean/RMS ignored while integrating, else resets display averaging.
// - Wiring codes 1-5; resets display and background averaging.
// - Line ends at LF or EOI byte; case and white space ignored.
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module mrc_parser #(
  parameter int COUPLE_CYC = `MRC_COUPLE_CYC  // One second hold-off
) (
  input  wire logic           i_clk,            // Instrument clock
  input  wire logic           i_rst_n,          // Async reset, active low
  input  wire logic           i_rx_valid,       // Received byte strobe
  input  wire logic [7:0]     i_rx_byte,        // Received byte
  input  wire logic           i_rx_eoi,         // Byte carried end-or-identify
  output logic                o_rx_ready,       // Parser can take a byte
  input  wire logic           i_mode_4882,      // 488.2 mode, level
  input  wire logic           i_cycle_end,      // Measurement cycle done pulse
  input  wire logic           i_bg_avg_max,     // Background averaging at max
  input  wire logic           i_disp_avg_max,   // Display averaging at max
  input  wire logic           i_cal_bad,        // Calibration missing
  input  wire logic           i_disp_rd,        // Talker reads display byte
  input  wire logic [7:0]     i_disp_char,      // Display char at o_disp_idx
  input  wire logic           i_poll,           // Serial poll read pulse
  output logic [5:0]          o_disp_idx,       // Display char index
  output logic [7:0]          o_disp_byte,      // Display stream byte
  output logic                o_disp_last,      // Byte is terminating LF
  output logic [7:0]          o_serial_poll_status, // Status byte
  output logic                o_srq,            // Service request line
  output mrc_pkg::mrc_cfg_type o_cfg,           // Current configuration
  output logic                o_store_load,     // Load results store pulse
  output logic                o_integ_capture,  // Capture integrator pulse
  output logic                o_disp_avg_reset, // Reset display avg pulse
  output logic                o_bg_avg_reset,   // Reset background avg pulse
  output logic                o_scale_amps,     // Amps factor written pulse
  output logic                o_scale_volts,    // Volts factor written pulse
  output logic                o_scale_down,     // Amps factor divides
  output logic [19:0]         o_scale_digits,   // Five BCD factor digits
  output logic                o_scale_led       // Factor not unity
);
  import mrc_pkg::*;

  typedef struct packed {
    mrc_state_type state;
    logic [7:0]    cmd;
    logic [7:0]    sub;
    logic          has_sub;
    logic          line_dead;
    logic          eoi_pend;
    logic [31:0]   wait_cnt;
    mrc_cfg_type   cfg;
    logic          armed;
    logic          ready;
    logic          srq;
    logic          disp_fresh;
    logic [5:0]    disp_idx;
    logic [7:0]    disp_byte;
    logic          disp_last;
    logic [7:0]    status;
    logic          store_load;
    logic          integ_cap;
    logic          disp_rst;
    logic          bg_rst;
    logic          sc_amps;
    logic          sc_volts;
    logic          sc_down;
    logic [19:0]   sc_digits;
    logic          amps_unity;
    logic          volts_unity;
  } mrc_top_type;

  mrc_top_type s;
  mrc_top_type next_s;
  mrc_arg_if   arg ();

  logic [7:0] ucase;
  logic       is_digit;
  logic       is_alpha;
  logic       is_space;
  logic       is_end;

  // Two-digit decimal value of the first two argument digits
  function automatic logic [6:0] dec2(input logic [31:0] d);
    logic [6:0] v;
    v = 7'(d[3:0]) * 7'h0A + 7'(d[7:4]);
    return v;
  endfunction

  // True when channel code is usable under the given wiring
  function automatic logic chan_ok(input logic [2:0] c, input logic [2:0] w);
    logic ok;
    ok = (c >= 3'h1) && (c <= 3'h5);
    if (w == `MRC_WIRE_1P2W && c != 3'h1) ok = 1'b0;
    if (w == `MRC_WIRE_C3ONLY && c != `MRC_CH_C3) ok = 1'b0;
    if (w != `MRC_WIRE_3P4W && c == `MRC_CH_NEU) ok = 1'b0;
    return ok;
  endfunction

  mrc_arg_store u_args (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .arg     (arg)
  );

  // Byte classification with case folding
  always_comb begin
    ucase    = (i_rx_byte >= 8'h61 && i_rx_byte <= 8'h7A) ?
               (i_rx_byte - 8'h20) : i_rx_byte;
    is_digit = (i_rx_byte >= 8'h30) && (i_rx_byte <= 8'h39) && i_rx_valid;
    is_alpha = (ucase >= 8'h41) && (ucase <= 8'h5A) && i_rx_valid;
    is_space = (i_rx_byte == 8'h20) || (i_rx_byte == 8'h09) ||
               (i_rx_byte == 8'h0D);
    is_end   = (i_rx_byte == `MRC_LF) || i_rx_eoi || s.eoi_pend;
  end

  // Next state: command execution, stores, display stream, status byte
  always_comb begin
    logic [6:0] v2;
    logic [5:0] n;
    logic       exec;
    logic       sep;
    next_s            = s;
    v2                = dec2(arg.digits);
    n                 = arg.count;
    exec              = 1'b0;
    sep               = 1'b0;
    arg.clr           = 1'b0;
    arg.push          = 1'b0;
    arg.digit         = i_rx_byte[3:0];
    next_s.store_load = 1'b0;
    next_s.integ_cap  = 1'b0;
    next_s.disp_rst   = 1'b0;
    next_s.bg_rst     = 1'b0;
    next_s.sc_amps    = 1'b0;
    next_s.sc_volts   = 1'b0;
    next_s.eoi_pend   = 1'b0;

    // Byte intake; a letter, semicolon, line end or stored EOI digit closes the command
    case (s.state)
      MRC_ST_IDLE, MRC_ST_ARGS: begin
        if (i_rx_valid || s.eoi_pend) begin
          if (is_digit && s.state == MRC_ST_ARGS && !s.eoi_pend) begin
            arg.push = 1'b1;
            next_s.eoi_pend = i_rx_eoi;
          end else if (is_end || is_alpha || i_rx_byte == 8'h3B) begin
            sep = 1'b1;
            exec = (s.state == MRC_ST_ARGS) && !s.line_dead;
          end
          // Second letter of two-letter commands
          if (is_alpha && s.state == MRC_ST_ARGS && n == 6'h00 &&
              !s.has_sub && (s.cmd == 8'h44 || s.cmd == 8'h4A ||
              s.cmd == 8'h4B)) begin
            sep = 1'b0;
            exec = 1'b0;
            next_s.sub = ucase;
            next_s.has_sub = 1'b1;
          end
        end
      end
      MRC_ST_WAIT: begin
        // Coupling hold-off: no bytes taken until it ends
        if (s.wait_cnt == 32'h0) next_s.state = MRC_ST_IDLE;
        else next_s.wait_cnt = s.wait_cnt - 32'h1;
      end
      default: next_s.state = MRC_ST_IDLE;
    endcase

    if (sep) begin
      arg.clr = 1'b1;
      next_s.has_sub = 1'b0;
      next_s.sub = 8'h00;
      next_s.state = is_alpha ? MRC_ST_ARGS : MRC_ST_IDLE;
      next_s.cmd = ucase;
      if (is_end) next_s.line_dead = 1'b0;
    end

    // Results store loads at the cycle end; a trigger taken now re-arms it
    if (i_cycle_end && s.armed &&
        s.cfg.source == MRC_SRC_BUFFER) begin
      next_s.store_load = 1'b1;
      next_s.armed = 1'b0;
    end

    // Execute one command; bad letter or count changes nothing
    if (exec) begin
      case (s.cmd)
        8'h42: begin
          if (n == 6'h01 && arg.digits[3:0] <= 4'h3)
            next_s.cfg.source = mrc_src_type'(arg.digits[1:0]);
          if (n == 6'h1C && arg.digits[3:0] == 4'h1 &&
              dec2(arg.digits >> 4) <= 7'(`MRC_CH_MAX) &&
              arg.digits[15:13] == 3'h0) begin
            next_s.cfg.source = MRC_SRC_BUFFER;
            next_s.cfg.res_channels = 5'(dec2(arg.digits >> 4));
            next_s.cfg.res_fund = arg.digits[12];
            next_s.cfg.res_funcs = arg.bits[`MRC_FUNC_DIGITS-1:0];
            next_s.armed = 1'b0;
          end
        end
        8'h54: if (n == 6'h01 && arg.digits[3:0] == 4'h1)
          next_s.armed = 1'b1;
        8'h49: if (n == 6'h01 && arg.digits[3:1] == 3'h0) begin
          next_s.cfg.integ_run = arg.digits[0];
          if (!arg.digits[0] && s.cfg.integ_run)
            next_s.integ_cap = 1'b1;
        end
        8'h43: if (n == 6'h01 &&
                   chan_ok(arg.digits[2:0], s.cfg.wiring) &&
                   arg.digits[3] == 1'b0) begin
          next_s.cfg.channel = arg.digits[2:0];
          next_s.disp_rst = 1'b1;
        end
        8'h44: if (s.has_sub && n == 6'h01) begin
          if (s.sub == 8'h4C && arg.digits[3] == 1'b0)
            next_s.cfg.top_left = arg.digits[2:0];
          if (s.sub == 8'h52 && arg.digits[3] == 1'b0)
            next_s.cfg.top_right = arg.digits[2:0];
          if (s.sub == 8'h4D && arg.digits[3:1] == 3'h0)
            next_s.cfg.sum_view = arg.digits[0];
        end
        8'h45: if (n == 6'h01 && arg.digits[3:1] == 3'h0 &&
                   s.cfg.wiring == `MRC_WIRE_3P4W)
          next_s.cfg.phase_phase = arg.digits[0];
        8'h46: if (n == 6'h02 && v2 <= 7'd23)
          next_s.cfg.main_func = 5'(v2);
        8'h47: if (n == 6'h01 && arg.digits[3:1] == 3'h0)
          next_s.cfg.fast_mode = arg.digits[0];
        8'h48: if (n == 6'h02) begin
          next_s.cfg.single_harm = v2;
          next_s.disp_rst = 1'b1;
        end
        8'h4A, 8'h4B: if (s.has_sub && n >= 6'h01 && n <= 6'h05 &&
                          (s.sub == 8'h55 ||
                          (s.sub == 8'h44 && s.cmd == 8'h4A)) &&
                          arg.digits[3:0] != 4'h0) begin
          next_s.sc_digits = arg.digits[19:0];
          next_s.sc_down = (s.sub == 8'h44);
          next_s.sc_amps = (s.cmd == 8'h4A);
          next_s.sc_volts = (s.cmd == 8'h4B);
          if (s.cmd == 8'h4A) next_s.amps_unity = (n == 6'h01) &&
                                (arg.digits[3:0] == 4'h1);
          else next_s.volts_unity = (n == 6'h01) &&
                                (arg.digits[3:0] == 4'h1);
          next_s.line_dead = !is_end;
        end
        8'h4C: if (n == 6'h03 && arg.digits[11:9] == 3'h0) begin
          next_s.cfg.harm_limit = v2;
          next_s.cfg.harm_odd = arg.digits[8];
        end
        8'h4D: if (n == 6'h01 && arg.digits[3:1] == 3'h0)
          next_s.cfg.srq_enable = arg.digits[0];
        8'h4E: if (n == 6'h01 && arg.digits[3:1] == 3'h0) begin
          next_s.cfg.ac_only = arg.digits[0];
          next_s.disp_rst = 1'b1;
          next_s.bg_rst = 1'b1;
          next_s.wait_cnt = 32'(COUPLE_CYC - 1);
          next_s.state = MRC_ST_WAIT;
        end
        8'h4F: if (n == 6'h01 && arg.digits[3:1] == 3'h0 &&
                   !s.cfg.integ_run) begin
          next_s.cfg.mean_mode = arg.digits[0];
          next_s.disp_rst = 1'b1;
        end
        8'h50: if (n == 6'h01 && arg.digits[3:0] >= 4'h1 &&
                   arg.digits[3:0] <= 4'h5) begin
          next_s.cfg.wiring = arg.digits[2:0];
          next_s.disp_rst = 1'b1;
          next_s.bg_rst = 1'b1;
        end
        default: ;
      endcase
    end

    // Data ready sets on new data; a poll clears, the set wins
    if (i_poll) next_s.ready = 1'b0;
    if (i_cycle_end) next_s.ready = 1'b1;
    next_s.srq = s.cfg.srq_enable & next_s.ready;

    // Display text outside 488.2 mode: 40 characters and LF once per cycle, else lone LF
    if (i_cycle_end) next_s.disp_fresh = 1'b1;
    if (i_disp_rd && s.cfg.source == MRC_SRC_DISPLAY && !i_mode_4882) begin
      if (s.disp_fresh && s.disp_idx < 6'(`MRC_DISP_LEN)) begin
        next_s.disp_byte = i_disp_char;
        next_s.disp_last = 1'b0;
        next_s.disp_idx = s.disp_idx + 6'h01;
      end else begin
        next_s.disp_byte = `MRC_LF;
        next_s.disp_last = 1'b1;
        next_s.disp_idx = 6'h00;
        if (s.disp_fresh && !i_cycle_end) next_s.disp_fresh = 1'b0;
      end
    end

    // Status byte, bits 3, 4 and 7 fixed low
    next_s.status = 8'h00;
    next_s.status[`MRC_SB_READY]    = next_s.ready;
    next_s.status[`MRC_SB_BG_MAX]   = i_bg_avg_max;
    next_s.status[`MRC_SB_DISP_MAX] = i_disp_avg_max;
    next_s.status[`MRC_SB_NOCAL]    = i_cal_bad;
    next_s.status[`MRC_SB_SRQ]      = next_s.srq;
  end

  // Parser state except the argument digits in one register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.state <= MRC_ST_IDLE;
      s.cfg.wiring <= `MRC_WIRE_1P2W;
      s.cfg.channel <= 3'h1;
      s.amps_unity <= 1'b1;
      s.volts_unity <= 1'b1;
      s.disp_byte <= `MRC_LF;
    end else begin
      s <= next_s;
    end
  end

  // Outputs; ready is low during the coupling hold-off only
  assign o_rx_ready           = (s.state != MRC_ST_WAIT);
  assign o_disp_idx           = s.disp_idx;
  assign o_disp_byte          = s.disp_byte;
  assign o_disp_last          = s.disp_last;
  assign o_serial_poll_status = s.status;
  assign o_srq                = s.srq;
  assign o_cfg                = s.cfg;
  assign o_store_load         = s.store_load;
  assign o_integ_capture      = s.integ_cap;
  assign o_disp_avg_reset     = s.disp_rst;
  assign o_bg_avg_reset       = s.bg_rst;
  assign o_scale_amps         = s.sc_amps;
  assign o_scale_volts        = s.sc_volts;
  assign o_scale_down         = s.sc_down;
  assign o_scale_digits       = s.sc_digits;
  assign o_scale_led          = !(s.amps_unity && s.volts_unity);
endmodule

// [design/mrc_cfg.svh]
// Constants for the remote command parser: codes, field positions, timing
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH
`define MRC_CLK_HZ        10000000
`define MRC_COUPLE_WAIT_MS 1000
`define MRC_COUPLE_CYC    ((`MRC_CLK_HZ / 1000) * `MRC_COUPLE_WAIT_MS)
`define MRC_DISP_LEN      40
`define MRC_CH_MAX        31
`define MRC_FUNC_DIGITS   24
`define MRC_SB_READY      0
`define MRC_SB_BG_MAX     1
`define MRC_SB_DISP_MAX   2
`define MRC_SB_NOCAL      5
`define MRC_SB_SRQ        6
`define MRC_CH_C3         3'h3
`define MRC_CH_SUM        3'h4
`define MRC_CH_NEU        3'h5
`define MRC_WIRE_1P2W     3'h1
`define MRC_WIRE_3P3W     3'h3
`define MRC_WIRE_3P4W     3'h4
`define MRC_WIRE_C3ONLY   3'h5
`define MRC_LF            8'h0A
`endif

// [design/mrc_pkg.sv]
// Types shared by the remote command parser modules
package mrc_pkg;
  typedef enum logic [1:0] {
    MRC_SRC_DISPLAY = 2'h0,
    MRC_SRC_BUFFER  = 2'h1,
    MRC_SRC_INTEG   = 2'h2,
    MRC_SRC_LOG     = 2'h3
  } mrc_src_type;

  typedef enum logic [4:0] {
    MRC_ST_IDLE  = 5'h01,
    MRC_ST_ARGS  = 5'h02,
    MRC_ST_SKIP  = 5'h04,
    MRC_ST_WAIT  = 5'h08,
    MRC_ST_DUMMY = 5'h10
  } mrc_state_type;

  typedef struct packed {
    logic [2:0]  wiring;
    logic [2:0]  channel;
    logic [2:0]  top_left;
    logic [2:0]  top_right;
    logic        sum_view;
    logic        phase_phase;
    logic [4:0]  main_func;
    logic        fast_mode;
    logic [6:0]  single_harm;
    logic [6:0]  harm_limit;
    logic        harm_odd;
    logic        srq_enable;
    logic        ac_only;
    logic        mean_mode;
    logic        integ_run;
    logic [4:0]  res_channels;
    logic        res_fund;
    logic [23:0] res_funcs;
    mrc_src_type source;
  } mrc_cfg_type;
endpackage

// [design/mrc_arg_if.sv]
// Argument digit buffer carrier between parser and argument store
`timescale 1ns/1ps
interface mrc_arg_if;
  logic        clr;     // Clear digit buffer
  logic        push;    // Append one digit
  logic [3:0]  digit;   // Digit value
  logic [5:0]  count;   // Digits held
  logic [31:0] digits;  // First digits, packed nibble per digit, 0 first
  logic [23:0] bits;    // Low bits of the last 24 digits, oldest at 0
  modport store (input clr, push, digit, output count, digits, bits);
  modport user  (output clr, push, digit, input count, digits, bits);
endinterface

// [design/mrc_arg_store.sv]
// Register store that collects the digits of one command argument
`timescale 1ns/1ps
module mrc_arg_store (
  input  wire logic i_clk,   // Instrument clock
  input  wire logic i_rst_n, // Async reset, active low
  mrc_arg_if.store  arg      // Digit buffer port
);
  import mrc_pkg::*;

  typedef struct packed {
    logic [5:0]  count;
    logic [31:0] digits;
    logic [23:0] bits;
  } mrc_store_type;

  mrc_store_type st;
  mrc_store_type next_st;

  // Append digits: first eight keep full value, last 24 keep a bit
  always_comb begin
    next_st = st;
    if (arg.clr) begin
      next_st = '0;
    end else if (arg.push && st.count < 6'h3F) begin
      if (st.count < 6'h08) begin
        next_st.digits[st.count[2:0]*4 +: 4] = arg.digit;
      end
      next_st.bits = {arg.digit[0], st.bits[23:1]};
      next_st.count = st.count + 6'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign arg.count  = st.count;
  assign arg.digits = st.digits;
  assign arg.bits   = st.bits;
endmodule

// [dv/mrc_parser_assertions.sv]
// Port checker for the remote command parser
`timescale 1ns/1ps
module mrc_parser_assertions #(
  parameter int COUPLE_CYC = 20 // Hold-off cycles
) (
  input wire logic                 i_clk,          // Clock
  input wire logic                 i_rst_n,        // Reset, low
  input wire logic                 i_cycle_end,    // Cycle end
  input wire logic                 i_bg_avg_max,   // Bg max
  input wire logic                 i_disp_avg_max, // Disp max
  input wire logic                 i_cal_bad,      // No calibration
  input wire logic                 o_rx_ready,     // Byte accept
  input wire logic [7:0]           o_serial_poll_status, // Status
  input wire logic                 o_srq,          // Request line
  input wire mrc_pkg::mrc_cfg_type o_cfg,          // Settings
  input wire logic                 o_store_load,   // Store load
  input wire logic                 o_disp_avg_reset, // Disp reset
  input wire logic                 o_bg_avg_reset  // Bg reset
);
  import mrc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] low_cnt;
  logic [2:0]  lv;
  assign lv = {i_cal_bad, i_disp_avg_max, i_bg_avg_max};
  // Length of the current refusal stretch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt <= 32'h0;
    else low_cnt <= o_rx_ready ? 32'h0 : low_cnt + 32'h1;
  end
  a_unused_zero: assert property (
    {o_serial_poll_status[7], o_serial_poll_status[4:3]} == 3'h0)
    else $error("Unused status bits set");
  a_status_live: assert property (
    1'b1 |=> {o_serial_poll_status[5], o_serial_poll_status[2:1]}
    == $past(lv)) else $error("Status bits lag inputs");
  a_srq_enabled: assert property (
    o_srq |-> o_cfg.srq_enable || $past(o_cfg.srq_enable))
    else $error("Request while disabled");
  a_holdoff_len: assert property (
    low_cnt <= COUPLE_CYC + 1) else $error("Hold-off too long");
  a_holdoff_min: assert property (
    $fell(o_rx_ready) |=> !o_rx_ready [*8])
    else $error("Hold-off too short");
  a_wiring_resets: assert property (
    $changed(o_cfg.wiring) |-> o_bg_avg_reset && o_disp_avg_reset)
    else $error("Wiring change without resets");
  a_couple_resets: assert property (
    $changed(o_cfg.ac_only) |-> o_bg_avg_reset && o_disp_avg_reset)
    else $error("Coupling change without resets");
  a_channel_reset: assert property (
    $changed(o_cfg.channel) |-> o_disp_avg_reset)
    else $error("Channel change without reset");
  a_mean_locked: assert property (
    $past(o_cfg.integ_run) |-> $stable(o_cfg.mean_mode))
    else $error("Mean changed while integrating");
  a_load_cause: assert property (
    o_store_load |-> $past(i_cycle_end) && o_cfg.source == MRC_SRC_BUFFER)
    else $error("Store load without cycle end");
endmodule
bind mrc_parser mrc_parser_assertions #(.COUPLE_CYC(COUPLE_CYC)) u_chk (
  .i_clk, .i_rst_n, .i_cycle_end, .i_bg_avg_max, .i_disp_avg_max,
  .i_cal_bad, .o_rx_ready, .o_serial_poll_status, .o_srq, .o_cfg,
  .o_store_load, .o_disp_avg_reset, .o_bg_avg_reset);

// [dv/mrc_host_model.sv]
// Bus controller model that sends command lines byte by byte
`timescale 1ns/1ps
module mrc_host_model (
  input  wire logic i_clk,   // Clock
  input  wire logic i_ready, // Parser takes bytes
  output logic      o_valid, // Byte strobe
  output logic [7:0] o_byte, // Byte
  output logic      o_eoi    // Last byte flag
);
  initial begin
    o_valid = 1'b0;
    o_byte = 8'hFF;
    o_eoi = 1'b0;
  end
  // Each byte stands until an edge sees ready; entered after an edge
  task automatic send(input string s, input bit eoi);
    for (int k = 0; k < s.len(); k++) begin
      o_valid = 1'b1;
      o_byte = s[k];
      o_eoi = eoi && (k == s.len() - 1);
      @(negedge i_clk);
      while (i_ready !== 1'b1) @(negedge i_clk);
      @(posedge i_clk);
      #1;
    end
    o_valid = 1'b0;
    o_byte = ~o_byte; // Released lines must not look like the last byte
    o_eoi = 1'b0;
  endtask
endmodule

// [dv/meter_remote_command_parser_tb.sv]
// Self-checking bench for the remote command parser
`timescale 1ns/1ps
module meter_remote_command_parser_tb;
  import mrc_pkg::*;
  typedef struct packed {mrc_cfg_type c; logic d; logic b;} mrc_note_type;
  logic clk, rst_n, cyc, bgm, dm, cal, drd, poll, m4882, rx_v, rx_eoi;
  logic rdy, last, srq, load_p, cap_p, dr_p, br_p, sa_p, sv_p, sdn, led;
  logic [7:0] rx_b, dbyte, st, dchar;
  logic [5:0] didx;
  logic [19:0] sdig;
  logic [15:0] r;
  mrc_cfg_type cfg, e, prev, seen;
  mrc_note_type q[$];
  int err_count, n_checks, loads, caps, scales, cycles;
  string fs;
  string bad[4] = '{"C6\n", "P9\n", "Z1\n", "F5\n"};
  assign dchar = 8'h30 + {2'h0, didx};
  mrc_host_model host (.i_clk(clk), .i_ready(rdy), .o_valid(rx_v),
    .o_byte(rx_b), .o_eoi(rx_eoi));
  mrc_parser #(.COUPLE_CYC(20)) uut (.i_clk(clk), .i_rst_n(rst_n),
    .i_rx_valid(rx_v), .i_rx_byte(rx_b), .i_rx_eoi(rx_eoi),
    .o_rx_ready(rdy), .i_mode_4882(m4882), .i_cycle_end(cyc),
    .i_bg_avg_max(bgm), .i_disp_avg_max(dm), .i_cal_bad(cal),
    .i_disp_rd(drd), .i_disp_char(dchar), .i_poll(poll),
    .o_disp_idx(didx), .o_disp_byte(dbyte), .o_disp_last(last),
    .o_serial_poll_status(st), .o_srq(srq), .o_cfg(cfg),
    .o_store_load(load_p), .o_integ_capture(cap_p),
    .o_disp_avg_reset(dr_p), .o_bg_avg_reset(br_p),
    .o_scale_amps(sa_p), .o_scale_volts(sv_p), .o_scale_down(sdn),
    .o_scale_digits(sdig), .o_scale_led(led));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  // A note is queued only where a visible result is due
  task automatic run(input string s, input bit d, input bit b,
                     input bit eoi = 1'b0);
    if (e !== prev || d || b) q.push_back({e, d, b});
    prev = e;
    host.send(s, eoi);
    tick(3);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Each settings change or averaging reset takes the oldest note
  always @(negedge clk) begin
    if (rst_n && (cfg !== seen || dr_p !== 1'b0 || br_p !== 1'b0)) begin
      seen = cfg;
      if (q.size() == 0) chk(1'b0, "unexpected result");
      else chk(q.pop_front() === {cfg, dr_p, br_p}, "result differs");
    end
  end
  // Pulse counters and a cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (load_p === 1'b1) loads++;
    if (cap_p === 1'b1) caps++;
    if (sa_p === 1'b1 || sv_p === 1'b1) scales++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {rst_n, cyc, bgm, dm, cal, drd, poll, m4882} = 8'h00;
    r = 16'h2CBF;
    e = '0;
    e.wiring = 3'h1;
    e.channel = 3'h1;
    prev = e;
    seen = e;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    for (int w = 1; w <= 5; w++) begin
      if (w == 5) begin
        e.channel = 3'h3;
        run("C3\n", 1, 0);
      end
      e.wiring = w[2:0];
      run($sformatf("p%0d\n", w), 1, 1);
    end
    run("C1\n", 0, 0);
    e.wiring = 3'h4;
    run("P4\n", 1, 1);
    e.phase_phase = 1'b1;
    run("E 1\n", 0, 0);
    for (int c = 5; c >= 4; c--) begin
      e.channel = c[2:0];
      run($sformatf("c%0d\n", c), 1, 0);
    end
    foreach (bad[i]) run(bad[i], 0, 0);
    $display("wiring test done");
    repeat (4) begin
      r = nxt(r);
      e.top_left = r[2:0];
      run($sformatf("DL%0d\n", r[2:0]), 0, 0);
      e.top_right = r[5:3];
      run($sformatf("dr%0d\n", r[5:3]), 0, 0);
      e.main_func = 5'(r % 24);
      run($sformatf("F%02d\n", r % 24), 0, 0);
      e.single_harm = 7'(r % 100);
      run($sformatf("H%02d\n", r % 100), 1, 0);
      e.harm_limit = 7'(r[15:8] % 100);
      e.harm_odd = r[0];
      run($sformatf("L%02d %0d\n", r[15:8] % 100, r[0]), 0, 0);
    end
    for (int k = 1; k >= 0; k--) begin
      e.sum_view = k[0];
      run($sformatf("DM%0d\n", k), 0, 0);
      e.fast_mode = k[0];
      run($sformatf("G%0d\n", k), 0, 0);
      e.srq_enable = k[0];
      run($sformatf("M%0d\n", k), 0, 0);
    end
    e.integ_run = 1'b1;
    run("I1\n", 0, 0);
    run("O1\n", 0, 0);
    e.integ_run = 1'b0;
    run("I0\n", 0, 0);
    chk(caps == 1, "capture count");
    e.mean_mode = 1'b1;
    run("o 1\n", 1, 0);
    e.ac_only = 1'b1;
    run("N1\n", 1, 1);
    chk(rdy === 1'b0, "no hold-off");
    e.ac_only = 1'b0;
    run("n0\n", 1, 1);
    $display("settings test done");
    run("JU1000;P2\n", 0, 0);
    chk(led === 1'b1 && sdn === 1'b0 && sdig[15:0] === 16'h0001, "up");
    run("JD10.5\n", 0, 0);
    chk(sdn === 1'b1 && led === 1'b1, "amps down");
    run("JU1\n", 0, 0);
    run("KU10.5\n", 0, 0);
    chk(led === 1'b1 && sdn === 1'b0, "volts up");
    run("KU1\n", 0, 0);
    chk(led === 1'b0 && scales == 5, "unity");
    fs = "000110110000000000000110";
    e.source = MRC_SRC_BUFFER;
    e.res_channels = 5'h13;
    e.res_fund = 1'b1;
    for (int i = 0; i < 24; i++) e.res_funcs[i] = (fs[i] == "1");
    run({"B1 19 1 ", fs, "\n"}, 0, 0);
    pulse(cyc);
    chk(loads == 0, "load without trigger");
    run("T1\n", 0, 0);
    pulse(cyc);
    chk(loads == 1, "triggered load");
    pulse(cyc);
    run("t1\n", 0, 0);
    pulse(cyc);
    chk(loads == 2, "rearmed load");
    $display("store test done");
    e.source = MRC_SRC_DISPLAY;
    run("B0\n", 0, 0);
    pulse(cyc);
    for (int k = 0; k <= 41; k++) begin
      pulse(drd);
      chk(dbyte === (k < 40 ? 8'h30 + 8'(k) : 8'h0A), "text");
      chk(k > 40 || last === (k == 40), "line end");
    end
    m4882 = 1'b1;
    pulse(cyc);
    pulse(drd);
    chk(dbyte === 8'h0A, "text in 488.2 mode");
    m4882 = 1'b0;
    pulse(poll);
    chk(st === 8'h00 && srq === 1'b0, "poll clear");
    e.srq_enable = 1'b1;
    run("M1", 0, 0, 1'b1);
    pulse(cyc);
    chk(st === 8'h41 && srq === 1'b1, "ready request");
    {cal, dm, bgm} = 3'h7;
    tick(2);
    chk(st === 8'h67, "status bits");
    pulse(poll);
    chk(st === 8'h26 && srq === 1'b0, "poll clears");
    $display("status test done");
    conclude();
  end
endmodule
